// *** rsc_pkg.sv ***
package rsc_pkg;

	localparam int ADR_W      = 8;
	localparam int DAT_W      = 32;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_HZ     = 25_000_000;
	localparam int TICK_MS    = 100;
	localparam int TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
	localparam int DETECT_MS  = 35;
	localparam int DETECT_CYC = CLK_HZ / 1000 * DETECT_MS;
	localparam int WINDOW_MS  = 50;
	localparam int WINDOW_CYC = CLK_HZ / 1000 * WINDOW_MS;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] ADR_SLEEP  = 8'h00;
	localparam logic [7:0] ADR_WAKE   = 8'h04;
	localparam logic [7:0] ADR_INITD  = 8'h08;
	localparam logic [7:0] ADR_IDLEI  = 8'h0c;
	localparam logic [7:0] ADR_DEST   = 8'h10;
	localparam logic [7:0] ADR_MASK   = 8'h14;
	localparam logic [7:0] ADR_SRC    = 8'h18;
	localparam logic [7:0] ADR_PRE    = 8'h1c;
	localparam logic [7:0] ADR_NET    = 8'h20;
	localparam logic [7:0] ADR_RETRY  = 8'h24;
	localparam logic [7:0] ADR_THRESH = 8'h28;
	localparam logic [7:0] ADR_GAP    = 8'h2c;
	localparam logic [7:0] ADR_PKMAX  = 8'h30;
	localparam logic [7:0] ADR_LIMIT  = 8'h34;
	localparam logic [7:0] ADR_SLOTS  = 8'h38;
	localparam logic [7:0] ADR_CTRL   = 8'h3c;
	localparam logic [7:0] ADR_STATUS = 8'h40;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [3:0]  RST_SLEEP  = 4'h0;
	localparam logic [15:0] RST_WAKE   = 16'h0064;
	localparam logic [7:0]  RST_INITD  = 8'h01;
	localparam logic [15:0] RST_IDLEI  = 16'hffff;
	localparam logic [15:0] RST_DEST   = 16'h0000;
	localparam logic [15:0] RST_MASK   = 16'h0000;
	localparam logic [15:0] RST_SRC    = 16'h0000;
	localparam logic [7:0]  RST_PRE    = 8'h00;
	localparam logic [15:0] RST_NET    = 16'h0000;
	localparam logic [7:0]  RST_RETRY  = 8'h00;
	localparam logic [15:0] RST_THRESH = 16'h0100;
	localparam logic [15:0] RST_GAP    = 16'h0003;
	localparam logic [15:0] RST_PKMAX  = 16'h0100;
	localparam logic [15:0] RST_LIMIT  = 16'hffff;
	localparam logic [7:0]  RST_SLOTS  = 8'h00;
	localparam logic [15:0] LFSR_SEED  = 16'hace1;

	////////////////////////////////////////////////////////////////////////
	// codes and fields
	localparam logic [3:0]  SLP_OFF     = 4'h0;
	localparam logic [3:0]  SLP_PIN     = 4'h1;
	localparam logic [3:0]  SLP_CYC_MIN = 4'h3;
	localparam logic [3:0]  SLP_CYC_MAX = 4'h8;
	localparam logic [15:0] WAKE_MIN    = 16'h0010;
	localparam logic [15:0] IDLE_NEVER  = 16'hffff;
	localparam logic [15:0] GLOBAL_ADDR = 16'hffff;
	localparam int CTRL_FORCE_INIT = 0;
	localparam int CTRL_ADDRESSED  = 1;

	typedef enum logic [1:0] {
		SL_ACTIVE, SL_ASLEEP, SL_WINDOW, SL_SYNC
	} rsc_sleep_type;

	typedef enum logic [2:0] {
		TX_IDLE, TX_FILL, TX_INIT, TX_SEND, TX_WAIT
	} rsc_tx_type;

endpackage : rsc_pkg

// *** rsc_ctrl.sv ***
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
module rsc_ctrl #(
	parameter int TICK_CYCLES   = rsc_pkg::TICK_CYC,
	parameter int DETECT_CYCLES = rsc_pkg::DETECT_CYC,
	parameter int WINDOW_CYCLES = rsc_pkg::WINDOW_CYC
) (
	input  wire  logic                      core_clk,
	input  wire  logic                      nrst,
	input  wire  logic                      wb_cyc_i,
	input  wire  logic                      wb_stb_i,
	input  wire  logic                      wb_we_i,
	input  wire  logic [rsc_pkg::ADR_W-1:0] wb_adr_i,
	input  wire  logic [rsc_pkg::DAT_W-1:0] wb_dat_i,
	input  wire  logic [3:0]                wb_sel_i,
	output logic       [rsc_pkg::DAT_W-1:0] wb_dat_o,
	output logic                            wb_ack_o,
	input  wire  logic                      sleep_pin,
	input  wire  logic                      radio_wake_detect,
	input  wire  logic                      rx_hdr_valid,
	input  wire  logic [7:0]                rx_preamble,
	input  wire  logic [15:0]               rx_net_ident,
	input  wire  logic [15:0]               rx_dest,
	input  wire  logic                      rx_data_valid,
	input  wire  logic [7:0]                rx_data,
	input  wire  logic                      rx_event_end,
	input  wire  logic [15:0]               din_count,
	input  wire  logic                      char_tick,
	input  wire  logic                      slot_tick,
	input  wire  logic                      tx_pkt_done,
	output logic                            tx_pkt_start,
	output logic       [15:0]               tx_pkt_len,
	output logic                            tx_pkt_global,
	output logic                            tx_pkt_with_init,
	output logic                            tx_init_on,
	output logic                            ser_out_valid,
	output logic       [7:0]                ser_out_data,
	output logic                            rx_accept,
	output logic                            rx_drop,
	output logic                            radio_sleep,
	output logic                            listen_window
);
	import rsc_pkg::*;

	logic [3:0]    sleep_setting;
	logic [15:0]   inactivity_wake_time;
	logic [7:0]    initializer_duration;
	logic [15:0]   idle_before_initializer;
	logic [15:0]   destination_addr;
	logic [15:0]   address_mask;
	logic [15:0]   source_addr;
	logic [7:0]    preamble_ident;
	logic [15:0]   vendor_net_ident;
	logic [7:0]    retry_count;
	logic [15:0]   packetize_byte_threshold;
	logic [15:0]   packetize_gap_timeout;
	logic [15:0]   max_packet_size;
	logic [15:0]   streaming_byte_limit;
	logic [7:0]    delay_slot_setting;
	logic          addressed;
	logic          bus_req;
	logic          bus_wr;
	logic          force_init;
	logic [2:0]    pin_sync;
	logic          pin_level;
	logic [21:0]   tick_cnt;
	logic          tick;
	logic [15:0]   idle_ticks;
	logic          activity;
	logic          is_cyclic;
	logic [15:0]   period_ticks;
	rsc_sleep_type slp_state;
	logic [15:0]   per_cnt;
	logic [21:0]   win_cnt;
	logic [21:0]   det_cnt;
	logic          pkt_open;
	logic          dst_ok;
	logic          hdr_ok;
	logic [15:0]   lfsr;
	logic [8:0]    rand_1n;
	logic [8:0]    rand_0n;
	rsc_tx_type    tx_state;
	logic [15:0]   sent;
	logic [15:0]   gap_cnt;
	logic [15:0]   din_prev;
	logic [8:0]    hold_slots;
	logic          need_init;
	logic [7:0]    init_ticks;
	logic          first_pkt;
	logic [15:0]   len_calc;
	logic [15:0]   room;
	logic [15:0]   sent_after;

	function automatic logic [15:0] wr16(input logic [15:0] old,
			input logic [31:0] d, input logic [3:0] sel);
		wr16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction : wr16

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: one wait state, write lands at the ack edge
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign bus_wr  = bus_req & wb_we_i & wb_ack_o;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sleep_setting            <= RST_SLEEP;
			inactivity_wake_time     <= RST_WAKE;
			initializer_duration     <= RST_INITD;
			idle_before_initializer  <= RST_IDLEI;
			destination_addr         <= RST_DEST;
			address_mask             <= RST_MASK;
			source_addr              <= RST_SRC;
			preamble_ident           <= RST_PRE;
			vendor_net_ident         <= RST_NET;
			retry_count              <= RST_RETRY;
			packetize_byte_threshold <= RST_THRESH;
			packetize_gap_timeout    <= RST_GAP;
			max_packet_size          <= RST_PKMAX;
			streaming_byte_limit     <= RST_LIMIT;
			delay_slot_setting       <= RST_SLOTS;
			addressed                <= 1'b0;
			force_init               <= 1'b0;
		end else begin
			force_init <= 1'b0;
			if (bus_wr) begin
				case (wb_adr_i)
				ADR_SLEEP: begin
					// codes 2 and above 8 are not modes; keep old value
					if (wb_sel_i[0] && wb_dat_i[7:0] <= 8'h08
							&& wb_dat_i[7:0] != 8'h02) begin
						sleep_setting <= wb_dat_i[3:0];
					end
				end
				ADR_WAKE: begin
					if (wr16(inactivity_wake_time, wb_dat_i, wb_sel_i)
							>= WAKE_MIN) begin
						inactivity_wake_time <= wr16(inactivity_wake_time,
							wb_dat_i, wb_sel_i);
					end
				end
				ADR_INITD: if (wb_sel_i[0]) initializer_duration <= wb_dat_i[7:0];
				ADR_IDLEI: idle_before_initializer <=
					wr16(idle_before_initializer, wb_dat_i, wb_sel_i);
				ADR_DEST: destination_addr <=
					wr16(destination_addr, wb_dat_i, wb_sel_i);
				ADR_MASK: address_mask <= wr16(address_mask, wb_dat_i, wb_sel_i);
				ADR_SRC: source_addr <= wr16(source_addr, wb_dat_i, wb_sel_i);
				ADR_PRE: if (wb_sel_i[0]) preamble_ident <= wb_dat_i[7:0];
				ADR_NET: vendor_net_ident <=
					wr16(vendor_net_ident, wb_dat_i, wb_sel_i);
				ADR_RETRY: if (wb_sel_i[0]) retry_count <= wb_dat_i[7:0];
				ADR_THRESH: packetize_byte_threshold <=
					wr16(packetize_byte_threshold, wb_dat_i, wb_sel_i);
				ADR_GAP: packetize_gap_timeout <=
					wr16(packetize_gap_timeout, wb_dat_i, wb_sel_i);
				ADR_PKMAX: max_packet_size <=
					wr16(max_packet_size, wb_dat_i, wb_sel_i);
				ADR_LIMIT: streaming_byte_limit <=
					wr16(streaming_byte_limit, wb_dat_i, wb_sel_i);
				ADR_SLOTS: if (wb_sel_i[0]) delay_slot_setting <= wb_dat_i[7:0];
				ADR_CTRL: begin
					if (wb_sel_i[0]) begin
						force_init <= wb_dat_i[CTRL_FORCE_INIT];
						addressed  <= wb_dat_i[CTRL_ADDRESSED];
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_ack_o) begin
			case (wb_adr_i)
			ADR_SLEEP:  wb_dat_o <= {28'h0, sleep_setting};
			ADR_WAKE:   wb_dat_o <= {16'h0, inactivity_wake_time};
			ADR_INITD:  wb_dat_o <= {24'h0, initializer_duration};
			ADR_IDLEI:  wb_dat_o <= {16'h0, idle_before_initializer};
			ADR_DEST:   wb_dat_o <= {16'h0, destination_addr};
			ADR_MASK:   wb_dat_o <= {16'h0, address_mask};
			ADR_SRC:    wb_dat_o <= {16'h0, source_addr};
			ADR_PRE:    wb_dat_o <= {24'h0, preamble_ident};
			ADR_NET:    wb_dat_o <= {16'h0, vendor_net_ident};
			ADR_RETRY:  wb_dat_o <= {24'h0, retry_count};
			ADR_THRESH: wb_dat_o <= {16'h0, packetize_byte_threshold};
			ADR_GAP:    wb_dat_o <= {16'h0, packetize_gap_timeout};
			ADR_PKMAX:  wb_dat_o <= {16'h0, max_packet_size};
			ADR_LIMIT:  wb_dat_o <= {16'h0, streaming_byte_limit};
			ADR_SLOTS:  wb_dat_o <= {24'h0, delay_slot_setting};
			ADR_CTRL:   wb_dat_o <= {30'h0, addressed, 1'b0};
			ADR_STATUS: wb_dat_o <= {sent, 8'h00, retry_count != 8'h00,
				pkt_open, need_init, tx_state, slp_state};
			default:    wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sleep pin: change taken once second and third stage agree
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pin_sync  <= 3'h0;
			pin_level <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], sleep_pin};
			if (pin_sync[1] == pin_sync[2]) pin_level <= pin_sync[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// 100 ms tick and idle time
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt <= 22'h0;
			tick     <= 1'b0;
		end else if (tick_cnt == 22'(TICK_CYCLES - 1)) begin
			tick_cnt <= 22'h0;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 22'h1;
			tick     <= 1'b0;
		end
	end

	assign activity = rx_hdr_valid | rx_data_valid | tx_pkt_start
		| (din_count != 16'h0) | (slp_state == SL_SYNC);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			idle_ticks <= 16'h0;
		end else if (activity) begin
			idle_ticks <= 16'h0;
		end else if (tick && idle_ticks != 16'hffff) begin
			idle_ticks <= idle_ticks + 16'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cyclic sleep
	assign is_cyclic = sleep_setting >= SLP_CYC_MIN
		&& sleep_setting <= SLP_CYC_MAX;

	always_comb begin
		case (sleep_setting)
		4'h3:    period_ticks = 16'h0005;
		4'h4:    period_ticks = 16'h000a;
		4'h5:    period_ticks = 16'h0014;
		4'h6:    period_ticks = 16'h0028;
		4'h7:    period_ticks = 16'h0050;
		default: period_ticks = 16'h00a0;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			slp_state <= SL_ACTIVE;
			per_cnt   <= 16'h0;
			win_cnt   <= 22'h0;
			det_cnt   <= 22'h0;
		end else if (!is_cyclic) begin
			slp_state <= SL_ACTIVE;
		end else begin
			case (slp_state)
			SL_ACTIVE: begin
				per_cnt <= 16'h0;
				if (!activity && idle_ticks >= inactivity_wake_time) begin
					slp_state <= SL_ASLEEP;
				end
			end
			SL_ASLEEP: begin
				if (din_count != 16'h0) begin
					slp_state <= SL_ACTIVE;
				end else if (tick) begin
					per_cnt <= per_cnt + 16'h1;
					if (per_cnt == period_ticks - 16'h1) begin
						slp_state <= SL_WINDOW;
						win_cnt   <= 22'h0;
						det_cnt   <= 22'h0;
					end
				end
			end
			SL_WINDOW: begin
				win_cnt <= win_cnt + 22'h1;
				det_cnt <= radio_wake_detect ? det_cnt + 22'h1 : 22'h0;
				if (radio_wake_detect
						&& det_cnt == 22'(DETECT_CYCLES - 1)) begin
					slp_state <= SL_SYNC;
				end else if (din_count != 16'h0) begin
					slp_state <= SL_ACTIVE;
				end else if (win_cnt == 22'(WINDOW_CYCLES - 1)) begin
					slp_state <= SL_ASLEEP;
					per_cnt   <= 16'h0;
				end
			end
			SL_SYNC: begin
				// receive starts only when the initializer has ended
				if (!radio_wake_detect) slp_state <= SL_ACTIVE;
			end
			default: slp_state <= SL_ACTIVE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			radio_sleep   <= 1'b0;
			listen_window <= 1'b0;
		end else begin
			radio_sleep <= (slp_state == SL_ASLEEP)
				| (sleep_setting == SLP_PIN & pin_level);
			listen_window <= slp_state == SL_WINDOW;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive filter; no acknowledgement is ever generated
	assign dst_ok = !addressed || rx_dest == source_addr
		|| (rx_dest | address_mask) == GLOBAL_ADDR;
	assign hdr_ok = rx_preamble == preamble_ident
		&& rx_net_ident == vendor_net_ident && dst_ok;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pkt_open      <= 1'b0;
			rx_accept     <= 1'b0;
			rx_drop       <= 1'b0;
			ser_out_valid <= 1'b0;
			ser_out_data  <= 8'h00;
		end else begin
			rx_accept <= rx_hdr_valid & hdr_ok;
			rx_drop   <= rx_hdr_valid & ~hdr_ok;
			if (rx_hdr_valid) pkt_open <= hdr_ok;
			ser_out_valid <= rx_data_valid & pkt_open;
			if (rx_data_valid) ser_out_data <= rx_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// back-off randomness
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lfsr <= LFSR_SEED;
		end else begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end

	always_comb begin
		if (delay_slot_setting == 8'h00) begin
			rand_1n = 9'h001;
			rand_0n = 9'h000;
		end else begin
			rand_0n = {1'b0, lfsr[7:0] % delay_slot_setting};
			rand_1n = rand_0n + 9'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// streaming transmit
	assign room = streaming_byte_limit - sent;

	always_comb begin
		len_calc = din_count;
		if (len_calc > max_packet_size) len_calc = max_packet_size;
		if (len_calc > room) len_calc = room;
	end

	assign sent_after = sent + tx_pkt_len;

	// initializer demand: a new set wins over the clear when it ends
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			need_init <= 1'b0;
		end else if (force_init || (idle_before_initializer != IDLE_NEVER
				&& idle_ticks >= idle_before_initializer)) begin
			need_init <= 1'b1;
		end else if (tx_state == TX_INIT && init_ticks
				>= initializer_duration) begin
			need_init <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			din_prev <= 16'h0;
			gap_cnt  <= 16'h0;
		end else begin
			din_prev <= din_count;
			if (din_count != din_prev || din_count == 16'h0) begin
				gap_cnt <= 16'h0;
			end else if (char_tick && gap_cnt != 16'hffff) begin
				gap_cnt <= gap_cnt + 16'h1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_state         <= TX_IDLE;
			sent             <= 16'h0;
			hold_slots       <= 9'h0;
			init_ticks       <= 8'h00;
			first_pkt        <= 1'b0;
			tx_pkt_start     <= 1'b0;
			tx_pkt_len       <= 16'h0;
			tx_pkt_global    <= 1'b0;
			tx_pkt_with_init <= 1'b0;
			tx_init_on       <= 1'b0;
		end else begin
			tx_pkt_start <= 1'b0;
			if (rx_event_end && delay_slot_setting != 8'h00
					&& rand_0n > hold_slots) begin
				hold_slots <= rand_0n;
			end else if (slot_tick && hold_slots != 9'h0) begin
				hold_slots <= hold_slots - 9'h1;
			end
			case (tx_state)
			TX_IDLE: begin
				if (din_count != 16'h0 && hold_slots == 9'h0
						&& slp_state == SL_ACTIVE) begin
					tx_state <= TX_FILL;
				end
			end
			TX_FILL: begin
				if (din_count >= packetize_byte_threshold
						|| gap_cnt >= packetize_gap_timeout) begin
					sent       <= 16'h0;
					first_pkt  <= 1'b1;
					init_ticks <= 8'h00;
					tx_state   <= need_init ? TX_INIT : TX_SEND;
					tx_init_on <= need_init;
				end
			end
			TX_INIT: begin
				if (init_ticks >= initializer_duration) begin
					tx_init_on <= 1'b0;
					tx_state   <= TX_SEND;
				end else if (tick) begin
					init_ticks <= init_ticks + 8'h01;
				end
			end
			TX_SEND: begin
				tx_pkt_start     <= 1'b1;
				tx_pkt_len       <= len_calc;
				tx_pkt_global    <= (destination_addr | address_mask)
					== GLOBAL_ADDR;
				tx_pkt_with_init <= first_pkt && init_ticks != 8'h00;
				tx_state         <= TX_WAIT;
			end
			TX_WAIT: begin
				if (tx_pkt_done) begin
					sent      <= sent_after;
					first_pkt <= 1'b0;
					if (sent_after >= streaming_byte_limit) begin
						hold_slots <= rand_1n;
						tx_state   <= TX_IDLE;
					end else if (din_count == 16'h0) begin
						hold_slots <= {1'b0, delay_slot_setting};
						tx_state   <= TX_IDLE;
					end else begin
						tx_state <= TX_SEND;
					end
				end
			end
			default: tx_state <= TX_IDLE;
			endcase
		end
	end

endmodule : rsc_ctrl

// *** rsc_ctrl_props.sv ***
`timescale 1ns/1ns
module rsc_ctrl_props (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        rx_hdr_valid,
	input wire logic        rx_data_valid,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_accept,
	input wire logic        rx_drop,
	input wire logic        ser_out_valid,
	input wire logic [7:0]  ser_out_data,
	input wire logic        tx_pkt_start,
	input wire logic [15:0] tx_pkt_len,
	input wire logic        radio_sleep
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	property p_verdict; rx_hdr_valid |=> rx_accept != rx_drop; endproperty
	a_verdict: assert property (p_verdict) else $error("no verdict");
	property p_cause; rx_accept || rx_drop |-> $past(rx_hdr_valid); endproperty
	a_cause: assert property (p_cause) else $error("stray verdict");
	property p_ser;
		ser_out_valid |-> $past(rx_data_valid) && ser_out_data == $past(rx_data);
	endproperty
	a_ser: assert property (p_ser) else $error("bad serial byte");
	property p_start; tx_pkt_start |=> !tx_pkt_start [*2]; endproperty
	a_start: assert property (p_start) else $error("start repeats");
	property p_awake; tx_pkt_start |-> !radio_sleep; endproperty
	a_awake: assert property (p_awake) else $error("send asleep");
	property p_len; tx_pkt_start |-> tx_pkt_len != 16'h0000; endproperty
	a_len: assert property (p_len) else $error("empty packet");
	c_acc: cover property (rx_accept);
	c_drop: cover property (rx_drop);
	c_start: cover property (tx_pkt_start);
endmodule : rsc_ctrl_props
bind rsc_ctrl rsc_ctrl_props rsc_ctrl_props_inst (.core_clk(core_clk),
	.nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .rx_hdr_valid(rx_hdr_valid),
	.rx_data_valid(rx_data_valid), .rx_data(rx_data), .rx_accept(rx_accept),
	.rx_drop(rx_drop), .ser_out_valid(ser_out_valid),
	.ser_out_data(ser_out_data), .tx_pkt_start(tx_pkt_start),
	.tx_pkt_len(tx_pkt_len), .radio_sleep(radio_sleep));

// *** rsc_radio_model.sv ***
`timescale 1ns/1ns
module rsc_radio_model (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        tx_pkt_start,
	input  wire logic [15:0] tx_pkt_len,
	input  wire logic        ld,
	input  wire logic [15:0] ldn,
	output logic      [15:0] din_count,
	output logic             tx_pkt_done,
	output logic             char_tick,
	output logic             slot_tick
);
	logic [3:0] tcnt;
	logic [2:0] busy;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			din_count <= 16'h0000;
			tcnt <= 4'h0;
			busy <= 3'h0;
			tx_pkt_done <= 1'b0;
		end else begin
			tcnt <= tcnt + 4'h1;
			tx_pkt_done <= busy == 3'h1;
			if (busy != 3'h0)
				busy <= busy - 3'h1;
			// host pops the packet bytes at once; load never overlaps
			if (tx_pkt_start) begin
				busy <= 3'h4;
				din_count <= din_count - tx_pkt_len;
			end else if (ld)
				din_count <= din_count + ldn;
		end
	end
	assign char_tick = tcnt[1:0] == 2'h3;
	assign slot_tick = tcnt == 4'hf;
endmodule : rsc_radio_model

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
	import rsc_pkg::*;
	logic core_clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0;
	logic hdr = 0, dv = 0, ld = 0, ack, done, ctk, stk, start, wi, ser;
	logic acc, drp, glb, ion, slp, lwin, spin = 0, wdet = 0;
	int n_ion = 0;
	logic [7:0] adr = 0, pre = 0, rxd = 0, sdat;
	logic [31:0] dat = 0, q, wdo;
	logic [15:0] net = 0, dst = 0, ldn = 0, dinc, len;
	int err_total = 0, checked = 0, n_acc = 0, n_drp = 0, n_ser = 0;
	logic [17:0] lens[$];
	initial forever #20 core_clk = ~core_clk;
	rsc_ctrl #(.TICK_CYCLES(20), .DETECT_CYCLES(7), .WINDOW_CYCLES(12))
	rsc_ctrl_inst (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(4'hf), .wb_dat_o(wdo), .wb_ack_o(ack), .sleep_pin(spin),
		.radio_wake_detect(wdet), .rx_hdr_valid(hdr), .rx_preamble(pre),
		.rx_net_ident(net), .rx_dest(dst), .rx_data_valid(dv), .rx_data(rxd),
		.rx_event_end(1'b0), .din_count(dinc), .char_tick(ctk),
		.slot_tick(stk), .tx_pkt_done(done), .tx_pkt_start(start),
		.tx_pkt_len(len), .tx_pkt_global(glb), .tx_pkt_with_init(wi),
		.tx_init_on(ion), .ser_out_valid(ser), .ser_out_data(sdat),
		.rx_accept(acc), .rx_drop(drp), .radio_sleep(slp),
		.listen_window(lwin));
	rsc_radio_model rsc_radio_model_inst (.core_clk(core_clk), .nrst(nrst),
		.tx_pkt_start(start), .tx_pkt_len(len), .ld(ld), .ldn(ldn),
		.din_count(dinc), .tx_pkt_done(done), .char_tick(ctk),
		.slot_tick(stk));
	always @(posedge core_clk) begin
		n_acc += acc;
		n_drp += drp;
		n_ser += ser;
		n_ion += ion;
		if (start === 1'b1)
			lens.push_back({glb, wi, len});
	end
	task end_of_test;
		$display("mismatches %0d of %0d checks", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
		do begin @(posedge core_clk); n++; end while (ack !== 1'b1 && n < 50);
		q = wdo;
		cyc <= 0; stb <= 0; we <= 0;
		if (n >= 50) begin err_total++; end_of_test; end
	endtask : wb
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(0, a, 0);
		chk("reg", q, e);
	endtask : rd
	task rx(input logic [7:0] p, input logic [15:0] nt, d, input logic [7:0] b);
		@(posedge core_clk); hdr <= 1; pre <= p; net <= nt; dst <= d;
		@(posedge core_clk); hdr <= 0; dv <= 1; rxd <= b; pre <= ~p;
		@(posedge core_clk); dv <= 0; rxd <= ~b; net <= ~nt; dst <= ~d;
		repeat (3) @(posedge core_clk);
	endtask : rx
	task automatic t_tx(input logic [15:0] n, input int k);
		int w;
		w = 0;
		lens.delete();
		@(posedge core_clk); ld <= 1; ldn <= n;
		@(posedge core_clk); ld <= 0;
		while (lens.size() < k && w < 3000) begin @(posedge core_clk); w++; end
		if (w >= 3000) begin err_total++; end_of_test; end
	endtask : t_tx
	task automatic wt(input int s, input logic v);
		int n;
		n = 0;
		while ((s == 0 ? slp : lwin) !== v && n < 2000) begin
			@(posedge core_clk); n++;
		end
		if ((s == 0 ? slp : lwin) !== v) begin err_total++; end_of_test; end
	endtask : wt
	task t_regs;
		rd(ADR_SLEEP, 0);
		rd(ADR_WAKE, 32'h64);
		rd(8'h7c, 0);
		for (int c = 0; c < 10; c++) begin
			wb(1, ADR_SLEEP, c);
			rd(ADR_SLEEP, c == 2 ? 1 : c > 8 ? 8 : c);
		end
		wb(1, ADR_SLEEP, 0);
		wb(1, ADR_WAKE, 32'h0f);
		rd(ADR_WAKE, 32'h64);
	endtask : t_regs
	task t_rx;
		wb(1, ADR_PRE, 32'h5a); wb(1, ADR_NET, 32'h1234);
		wb(1, ADR_SRC, 32'h42); wb(1, ADR_CTRL, 32'h2);
		rx(8'h5a, 16'h1234, 16'h0042, 8'ha1);
		rx(8'h5a, 16'h1235, 16'h0042, 8'hb2);
		rx(8'h5b, 16'h1234, 16'h0042, 8'hc3);
		rx(8'h5a, 16'h1234, 16'h0043, 8'hd4);
		wb(1, ADR_CTRL, 0);
		rx(8'h5a, 16'h1234, 16'h0043, 8'he5);
		chk("accepts", n_acc, 2);
		chk("drops", n_drp, 3);
		chk("bytes out", n_ser, 2);
		chk("last byte", sdat, 8'he5);
	endtask : t_rx
	task t_stream;
		wb(1, ADR_RETRY, 0);
		wb(1, ADR_THRESH, 4); wb(1, ADR_PKMAX, 3);
		wb(1, ADR_CTRL, 1);
		t_tx(5, 2);
		chk("pkt0", lens[0], 17'h10003);
		chk("pkt1", lens[1], 17'h00002);
		chk("init on", n_ion >= 2 && n_ion <= 21, 1);
		wb(1, ADR_LIMIT, 4);
		wb(1, ADR_DEST, 32'hffff);
		t_tx(6, 3);
		chk("lim0", lens[0], 18'h20003);
		chk("lim1", lens[1], 18'h20001);
		chk("lim2", lens[2], 18'h20002);
		chk("global", lens[0][17], 1);
	endtask : t_stream
	task t_sleep;
		wb(1, ADR_WAKE, 32'h10);
		wb(1, ADR_SLEEP, 3);
		wt(0, 1);
		wb(0, ADR_STATUS, 0);
		chk("asleep", q[1:0], 1);
		wt(1, 1);
		wt(1, 0);
		chk("no init", slp, 1);
		wt(1, 1);
		wdet <= 1;
		repeat (9) @(posedge core_clk);
		chk("synced", {slp, lwin}, 0);
		wb(0, ADR_STATUS, 0);
		chk("sync state", q[1:0], 3);
		wdet <= 0;
		repeat (3) @(posedge core_clk);
		wb(0, ADR_STATUS, 0);
		chk("awake", q[1:0], 0);
		wb(1, ADR_SLEEP, 1);
		spin <= 1;
		repeat (7) @(posedge core_clk);
		chk("pin sleep", slp, 1);
		spin <= 0;
		repeat (7) @(posedge core_clk);
		chk("pin wake", slp, 0);
		wb(1, ADR_SLEEP, 0);
	endtask : t_sleep
	initial begin
		repeat (20) @(posedge core_clk);
		nrst <= 1;
		t_regs;
		t_rx;
		t_stream;
		t_sleep;
		end_of_test;
	end
endmodule : tb_top
